// ---- rtl/cpu_core_debug_unit.sv ----
// core debug unit: JTAG command link, run control and trace port
`timescale 1ns/1ns
`default_nettype none
module cpu_core_debug_unit (
    input wire logic sys_clk_in, // core clock
    input wire logic rst_n_in, // async reset, active low
    input wire logic jtag_tck_in, // link clock from tool
    input wire logic jtag_tms_in, // high while a frame shifts
    input wire logic jtag_tdi_in, // serial data from tool
    output logic jtag_tdo_out, // serial data to tool
    input wire logic [1:0] debug_mode_in, // debug_unit_pkg::debug_mode_type code
    input wire logic core_event_in, // core debug event
    input wire logic core_sw_bp_in, // core hit a trap breakpoint
    input wire logic core_retire_in, // instruction retired
    input wire logic [debug_unit_pkg::DATA_W-1:0] core_pc_in, // retired address
    input wire logic core_isr_done_in, // handler returned
    input wire logic irq_in, // combined interrupt request
    output logic core_stop_out, // hold core execution
    output logic core_wait_out, // core in wait state
    output logic core_dbg_exc_out, // debug exception pulse
    output logic core_irq_take_out, // vector to interrupt pulse
    output logic timer_freeze_out, // freeze core timers
    output logic [debug_unit_pkg::REG_ADDR_W-1:0] core_reg_addr_out, // resource select
    output logic [debug_unit_pkg::DATA_W-1:0] core_reg_wdata_out, // resource write data
    output logic core_reg_we_out, // resource write pulse
    output logic core_reg_re_out, // resource read pulse
    input wire logic [debug_unit_pkg::DATA_W-1:0] core_reg_rdata_in, // resource read data
    output logic [debug_unit_pkg::DATA_W-1:0] icache_addr_out, // cache fill address
    output logic [debug_unit_pkg::DATA_W-1:0] icache_data_out, // cache fill word
    output logic icache_we_out, // cache fill pulse
    output logic trace_valid_out, // trace word valid
    output logic [debug_unit_pkg::DATA_W-1:0] trace_pc_out, // traced address
    output logic trace_event_out // debug event marker
);
    import debug_unit_pkg::*;

    // reset release, core domain
    logic rst_meta_reg;
    logic rst_n;
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    // reset release, link domain
    logic tck_rst_meta_reg;
    logic tck_rst_n;
    always_ff @(posedge jtag_tck_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tck_rst_meta_reg <= 1'b0;
            tck_rst_n <= 1'b0;
        end else begin
            tck_rst_meta_reg <= 1'b1;
            tck_rst_n <= tck_rst_meta_reg;
        end
    end

    // link domain: frame shifter
    logic [FRAME_W-1:0] shift_reg;
    logic [FRAME_W-1:0] cmd_hold_reg;
    logic [FRAME_W-1:0] out_reg;
    logic [CNT_W-1:0] bit_cnt_reg;
    logic in_frame_reg;
    logic cmd_tgl_reg;
    logic ack_meta_reg;
    logic ack_sync_reg;
    logic resp_ack_reg;
    logic [STAT_W-2:0] status_reg;
    logic [DATA_W-1:0] resp_data_reg;

    always_ff @(posedge jtag_tck_in or negedge tck_rst_n) begin
        if (!tck_rst_n) begin
            shift_reg <= '0;
            bit_cnt_reg <= '0;
            in_frame_reg <= 1'b0;
        end else begin
            in_frame_reg <= jtag_tms_in;
            if (jtag_tms_in) begin
                shift_reg <= {jtag_tdi_in, shift_reg[FRAME_W-1:1]};
                if (bit_cnt_reg != FRAME_LEN) begin
                    bit_cnt_reg <= bit_cnt_reg + CNT_ONE;
                end
            end else begin
                bit_cnt_reg <= '0;
            end
        end
    end

    // commit a whole frame on its closing edge
    always_ff @(posedge jtag_tck_in or negedge tck_rst_n) begin
        if (!tck_rst_n) begin
            cmd_hold_reg <= '0;
            cmd_tgl_reg <= 1'b0;
        end else if (in_frame_reg && !jtag_tms_in && bit_cnt_reg == FRAME_LEN) begin
            cmd_hold_reg <= shift_reg;
            cmd_tgl_reg <= ~cmd_tgl_reg;
        end
    end

    always_ff @(posedge jtag_tck_in or negedge tck_rst_n) begin
        if (!tck_rst_n) begin
            ack_meta_reg <= 1'b0;
            ack_sync_reg <= 1'b0;
        end else begin
            ack_meta_reg <= resp_ack_reg;
            ack_sync_reg <= ack_meta_reg;
        end
    end

    // answer word reloads on idle edges, shifts out lsb first
    always_ff @(posedge jtag_tck_in or negedge tck_rst_n) begin
        if (!tck_rst_n) begin
            out_reg <= '0;
        end else if (jtag_tms_in) begin
            out_reg <= {1'b0, out_reg[FRAME_W-1:1]};
        end else begin
            out_reg <= {ack_sync_reg, status_reg, resp_data_reg};
        end
    end
    assign jtag_tdo_out = out_reg[0];

    // core domain: command toggle crossing
    logic tgl_meta_reg;
    logic tgl_sync_reg;
    logic tgl_seen_reg;
    logic cmd_stb;
    cmd_type cmd_code;
    logic [DATA_W-1:0] cmd_data;
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            tgl_meta_reg <= 1'b0;
            tgl_sync_reg <= 1'b0;
            tgl_seen_reg <= 1'b0;
        end else begin
            tgl_meta_reg <= cmd_tgl_reg;
            tgl_sync_reg <= tgl_meta_reg;
            tgl_seen_reg <= tgl_sync_reg;
        end
    end
    assign cmd_stb = tgl_sync_reg ^ tgl_seen_reg;
    assign cmd_code = cmd_type'(cmd_hold_reg[FRAME_W-1:DATA_W]);
    assign cmd_data = cmd_hold_reg[DATA_W-1:0];

    // interrupt request arrives from outside merge logic
    logic irq_meta_reg;
    logic irq_sync_reg;
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            irq_meta_reg <= 1'b0;
            irq_sync_reg <= 1'b0;
        end else begin
            irq_meta_reg <= irq_in;
            irq_sync_reg <= irq_meta_reg;
        end
    end

    // mode select, undefined code falls back to internal
    debug_mode_type mode;
    always_comb begin
        case (debug_mode_in)
            MODE_EXTERNAL: mode = MODE_EXTERNAL;
            MODE_WAIT: mode = MODE_WAIT;
            default: mode = MODE_INTERNAL;
        endcase
    end

    // breakpoints and event detection
    logic [DATA_W-1:0] bp_addr_reg;
    logic bp_en_reg;
    logic bp_hit;
    logic event_now;
    logic [REG_ADDR_W-1:0] reg_sel_reg;
    run_state_type state_reg;
    run_state_type state_next;
    assign bp_hit = bp_en_reg && core_retire_in && core_pc_in == bp_addr_reg;
    assign event_now = state_reg == ST_RUN && (core_event_in || core_sw_bp_in || bp_hit);

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            bp_addr_reg <= ZERO_WORD;
            bp_en_reg <= 1'b0;
        end else if (cmd_stb && cmd_code == CMD_SET_BP) begin
            bp_addr_reg <= cmd_data;
            bp_en_reg <= 1'b1;
        end else if (cmd_stb && cmd_code == CMD_CLR_BP) begin
            bp_en_reg <= 1'b0;
        end
    end

    // run control
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (cmd_stb && cmd_code == CMD_HALT) begin
                    state_next = ST_STOPPED;
                end else if (event_now && mode == MODE_EXTERNAL) begin
                    state_next = ST_STOPPED;
                end else if (event_now && mode == MODE_WAIT) begin
                    state_next = ST_WAITING;
                end
            end
            ST_STOPPED: begin
                if (cmd_stb && cmd_code == CMD_RESUME) begin
                    state_next = ST_RUN;
                end else if (cmd_stb && cmd_code == CMD_STEP) begin
                    state_next = ST_STEPPING;
                end
            end
            ST_STEPPING: begin
                if (core_retire_in) begin
                    state_next = ST_STOPPED;
                end
            end
            ST_WAITING: begin
                if (irq_sync_reg) begin
                    state_next = ST_SERVICING;
                end else if (cmd_stb && cmd_code == CMD_RESUME) begin
                    state_next = ST_RUN;
                end else if (cmd_stb && cmd_code == CMD_STEP) begin
                    state_next = ST_STEPPING;
                end
            end
            ST_SERVICING: begin
                if (core_isr_done_in) begin
                    state_next = ST_WAITING;
                end
            end
            default: state_next = ST_STOPPED;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_RUN;
            core_stop_out <= 1'b0;
            core_wait_out <= 1'b0;
            core_irq_take_out <= 1'b0;
        end else begin
            state_reg <= state_next;
            core_stop_out <= state_next == ST_STOPPED || state_next == ST_WAITING;
            core_wait_out <= state_next == ST_WAITING || state_next == ST_SERVICING;
            core_irq_take_out <= state_reg == ST_WAITING && state_next == ST_SERVICING;
        end
    end

    // internal mode trap and trace marker
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            core_dbg_exc_out <= 1'b0;
            trace_event_out <= 1'b0;
        end else begin
            core_dbg_exc_out <= event_now && mode == MODE_INTERNAL;
            trace_event_out <= event_now;
        end
    end

    // trace broadcast, independent of mode
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            trace_valid_out <= 1'b0;
            trace_pc_out <= ZERO_WORD;
        end else begin
            trace_valid_out <= core_retire_in;
            trace_pc_out <= core_pc_in;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            timer_freeze_out <= 1'b0;
        end else if (cmd_stb && cmd_code == CMD_FREEZE) begin
            timer_freeze_out <= 1'b1;
        end else if (cmd_stb && cmd_code == CMD_THAW) begin
            timer_freeze_out <= 1'b0;
        end
    end

    // core resource access
    logic rd_pend_reg;
    logic ack_pend_reg;
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            reg_sel_reg <= '0;
            core_reg_addr_out <= '0;
            core_reg_wdata_out <= ZERO_WORD;
            core_reg_we_out <= 1'b0;
            core_reg_re_out <= 1'b0;
        end else begin
            core_reg_we_out <= cmd_stb && cmd_code == CMD_WR_REG;
            core_reg_re_out <= cmd_stb && cmd_code == CMD_RD_REG;
            core_reg_addr_out <= reg_sel_reg;
            if (cmd_stb && cmd_code == CMD_SEL_REG) begin
                reg_sel_reg <= cmd_data[REG_ADDR_W-1:0];
                core_reg_addr_out <= cmd_data[REG_ADDR_W-1:0];
            end
            if (cmd_stb && cmd_code == CMD_WR_REG) begin
                core_reg_wdata_out <= cmd_data;
            end
        end
    end

    // instruction cache fill, address steps one word per write
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            icache_addr_out <= ZERO_WORD;
            icache_data_out <= ZERO_WORD;
            icache_we_out <= 1'b0;
        end else begin
            icache_we_out <= cmd_stb && cmd_code == CMD_IC_WR;
            if (cmd_stb && cmd_code == CMD_IC_ADDR) begin
                icache_addr_out <= cmd_data;
            end else if (icache_we_out) begin
                icache_addr_out <= icache_addr_out + ICACHE_STEP;
            end
            if (cmd_stb && cmd_code == CMD_IC_WR) begin
                icache_data_out <= cmd_data;
            end
        end
    end

    // answer: data first, acknowledge one cycle later
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            rd_pend_reg <= 1'b0;
            ack_pend_reg <= 1'b0;
            resp_data_reg <= ZERO_WORD;
            resp_ack_reg <= 1'b0;
            status_reg <= '0;
        end else begin
            rd_pend_reg <= core_reg_re_out;
            ack_pend_reg <= (cmd_stb && cmd_code != CMD_RD_REG) || rd_pend_reg;
            if (rd_pend_reg) begin
                resp_data_reg <= core_reg_rdata_in;
            end
            // status frozen with the ack, settled before the ack is synced
            if (ack_pend_reg) begin
                resp_ack_reg <= tgl_seen_reg;
                status_reg <= {state_reg, mode, timer_freeze_out, bp_en_reg};
            end
        end
    end

endmodule : cpu_core_debug_unit
`default_nettype wire

// ---- rtl/debug_unit_pkg.sv ----
// constants and types shared by the core debug unit
package debug_unit_pkg;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned CMD_W = 8;
    localparam int unsigned STAT_W = 8;
    localparam int unsigned FRAME_W = 40;
    localparam int unsigned REG_ADDR_W = 8;
    localparam int unsigned CNT_W = 6;
    localparam logic [CNT_W-1:0] FRAME_LEN = 6'h28;
    localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
    localparam logic [DATA_W-1:0] ICACHE_STEP = 32'h0000_0004;
    localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

    typedef enum logic [CMD_W-1:0] {
        CMD_NOP = 8'h00,
        CMD_HALT = 8'h01,
        CMD_RESUME = 8'h02,
        CMD_STEP = 8'h03,
        CMD_FREEZE = 8'h04,
        CMD_THAW = 8'h05,
        CMD_SEL_REG = 8'h06,
        CMD_RD_REG = 8'h07,
        CMD_WR_REG = 8'h08,
        CMD_SET_BP = 8'h09,
        CMD_CLR_BP = 8'h0a,
        CMD_IC_ADDR = 8'h0b,
        CMD_IC_WR = 8'h0c
    } cmd_type;

    typedef enum logic [1:0] {
        MODE_INTERNAL = 2'h0,
        MODE_EXTERNAL = 2'h1,
        MODE_WAIT = 2'h2
    } debug_mode_type;

    typedef enum logic [2:0] {
        ST_RUN = 3'h0,
        ST_STOPPED = 3'h1,
        ST_STEPPING = 3'h3,
        ST_WAITING = 3'h2,
        ST_SERVICING = 3'h6
    } run_state_type;
endpackage : debug_unit_pkg

// ---- dv/debug_unit_sva.sv ----
// assertion checker for the debug unit run control and trace port
`timescale 1ns/1ns
`default_nettype none
module debug_unit_sva (
    input wire logic sys_clk_in, // core clock
    input wire logic rst_n_in, // async reset
    input wire logic [1:0] debug_mode_in, // mode code
    input wire logic core_retire_in, // retire pulse
    input wire logic [debug_unit_pkg::DATA_W-1:0] core_pc_in, // retired address
    input wire logic core_isr_done_in, // handler done
    input wire logic irq_in, // combined interrupt
    input wire logic core_stop_out, // stop level
    input wire logic core_wait_out, // wait level
    input wire logic core_dbg_exc_out, // exception pulse
    input wire logic core_irq_take_out, // vector pulse
    input wire logic [debug_unit_pkg::DATA_W-1:0] icache_addr_out, // fill address
    input wire logic icache_we_out, // fill pulse
    input wire logic trace_valid_out, // trace valid
    input wire logic [debug_unit_pkg::DATA_W-1:0] trace_pc_out, // trace address
    input wire logic trace_event_out // event marker
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    sequence s_waiting_irq;
        (core_stop_out && core_wait_out && irq_in) [*3];
    endsequence
    sequence s_servicing;
        !core_stop_out && core_wait_out;
    endsequence
    a_ext_event_stop: assert property (
        trace_event_out && $past(debug_mode_in) == 2'h1 |-> core_stop_out && !core_wait_out)
        else $error("external event did not stop the core");
    a_wait_event_enter: assert property (
        trace_event_out && $past(debug_mode_in) == 2'h2 |-> core_stop_out && core_wait_out)
        else $error("wait mode event did not enter wait");
    a_int_event_trap: assert property (
        trace_event_out && $past(debug_mode_in) inside {2'h0, 2'h3}
        |-> core_dbg_exc_out && !core_stop_out)
        else $error("internal event did not trap");
    a_exc_has_cause: assert property (
        core_dbg_exc_out |-> trace_event_out ##1 !core_dbg_exc_out)
        else $error("exception pulse without event");
    a_trace_follows: assert property (
        core_retire_in |=> trace_valid_out && trace_pc_out == $past(core_pc_in))
        else $error("trace word missing");
    a_irq_wakes_wait: assert property (
        s_waiting_irq |-> ##[0:2] core_irq_take_out)
        else $error("interrupt not taken in wait");
    a_take_to_service: assert property (
        core_irq_take_out |-> $past(core_stop_out && core_wait_out) ##0 s_servicing)
        else $error("vector outside wait state");
    a_isr_back_wait: assert property (
        core_isr_done_in && !core_stop_out && core_wait_out |=> core_stop_out && core_wait_out)
        else $error("no return to wait");
    a_icache_step: assert property (
        icache_we_out |=> icache_addr_out == $past(icache_addr_out) + 32'h0000_0004)
        else $error("fill address did not step");
endmodule : debug_unit_sva
bind cpu_core_debug_unit debug_unit_sva sva (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .debug_mode_in(debug_mode_in), .core_retire_in(core_retire_in), .core_pc_in(core_pc_in),
    .core_isr_done_in(core_isr_done_in), .irq_in(irq_in), .core_stop_out(core_stop_out),
    .core_wait_out(core_wait_out), .core_dbg_exc_out(core_dbg_exc_out),
    .core_irq_take_out(core_irq_take_out), .icache_addr_out(icache_addr_out),
    .icache_we_out(icache_we_out), .trace_valid_out(trace_valid_out),
    .trace_pc_out(trace_pc_out), .trace_event_out(trace_event_out));
`default_nettype wire

// ---- dv/debug_tool_model.sv ----
// behavioural debug tool on the serial command link
`timescale 1ns/1ns
`default_nettype none
module debug_tool_model (
    output logic jtag_tck_out, // link clock, low between ticks, idle ticks with tms low between frames
    output logic jtag_tms_out, // frame marker
    output logic jtag_tdi_out, // serial command
    input wire logic jtag_tdo_in // serial answer
);
    initial begin
        jtag_tck_out = 1'b0;
        jtag_tms_out = 1'b0;
        jtag_tdi_out = 1'b0;
    end
    task automatic tick(input logic tms, input logic tdi);
        jtag_tms_out = tms;
        jtag_tdi_out = tdi;
        #24 jtag_tck_out = 1'b1;
        #24 jtag_tck_out = 1'b0;
    endtask : tick
    // released data line toggles so a stale bit is never seen
    task automatic idle(input int n);
        repeat (n) tick(1'b0, ~jtag_tdi_out);
    endtask : idle
    // frame lsb first, commit, then settle so the ack is loaded
    task automatic xfer(input logic [7:0] c, input logic [31:0] d, output logic [39:0] ans);
        logic [39:0] bits;
        bits = {c, d};
        for (int i = 0; i < 40; i++) begin
            ans[i] = jtag_tdo_in;
            tick(1'b1, bits[i]);
        end
        idle(1);
        #800;
        idle(3);
    endtask : xfer
endmodule : debug_tool_model
`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench for the core debug unit
`timescale 1ns/1ns
`default_nettype none
module tb;
    import debug_unit_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic tck, tms, tdi, tdo, stop, wt, exc, take, frz, we, re, icwe, tv, tev;
    logic [1:0] mode = 2'h1;
    logic ev = 1'b0, bp = 1'b0, ret = 1'b0, isr = 1'b0, irq = 1'b0;
    logic [31:0] pc = 32'h0000_0000, rdata = 32'h0000_0000;
    logic [31:0] wdata, icaddr, icdata, tpc, we_d, ic_a, ic_d;
    logic [7:0] raddr, we_a, re_a;
    logic [39:0] ans;
    int miscompares = 0, n_compared = 0, cyc = 0, ncmd = 0, ic_n = 0;
    always #50 sys_clk = ~sys_clk;
    cpu_core_debug_unit dut (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .jtag_tck_in(tck),
        .jtag_tms_in(tms), .jtag_tdi_in(tdi), .jtag_tdo_out(tdo), .debug_mode_in(mode),
        .core_event_in(ev), .core_sw_bp_in(bp), .core_retire_in(ret), .core_pc_in(pc),
        .core_isr_done_in(isr), .irq_in(irq), .core_stop_out(stop), .core_wait_out(wt),
        .core_dbg_exc_out(exc), .core_irq_take_out(take), .timer_freeze_out(frz),
        .core_reg_addr_out(raddr), .core_reg_wdata_out(wdata), .core_reg_we_out(we),
        .core_reg_re_out(re), .core_reg_rdata_in(rdata), .icache_addr_out(icaddr),
        .icache_data_out(icdata), .icache_we_out(icwe), .trace_valid_out(tv),
        .trace_pc_out(tpc), .trace_event_out(tev));
    debug_tool_model tool (.jtag_tck_out(tck), .jtag_tms_out(tms), .jtag_tdi_out(tdi),
        .jtag_tdo_in(tdo));
    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
    // core register file answer and pulse capture
    always @(negedge sys_clk) begin
        rdata <= 32'h5a5a_5a00 | {24'h00_0000, raddr};
        if (we) begin
            we_a = raddr;
            we_d = wdata;
        end
        if (re) begin
            re_a = raddr;
        end
        if (icwe) begin
            ic_n++;
            ic_a = icaddr;
            ic_d = icdata;
        end
        cyc++;
        if (cyc > 6000) begin
            miscompares++;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic fire(input logic [1:0] m, input logic sw);
        mode = m;
        @(negedge sys_clk);
        ev = ~sw;
        bp = sw;
        @(negedge sys_clk);
        ev = 1'b0;
        bp = 1'b0;
    endtask : fire
    task automatic cmd(input cmd_type c, input logic [31:0] d);
        tool.xfer(c, d, ans);
        ncmd++;
        @(negedge sys_clk);
    endtask : cmd
    task automatic retire(input logic [31:0] v);
        pc = v;
        ret = 1'b1;
        @(negedge sys_clk);
        ret = 1'b0;
    endtask : retire
    initial begin
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        tool.idle(3);
        @(negedge sys_clk);
        chk(32'({stop, wt, frz, tev, exc}), 32'h0000_0000, "reset levels");
        fire(2'h1, 1'b0);
        chk(32'({stop, wt, tev}), 32'h0000_0005, "external event");
        fire(2'h1, 1'b0);
        chk(32'({stop, tev}), 32'h0000_0002, "event while stopped");
        cmd(CMD_FREEZE, 32'h0000_0000);
        chk(32'(frz), 32'h0000_0001, "freeze");
        cmd(CMD_THAW, 32'h0000_0000);
        chk(32'(frz), 32'h0000_0000, "thaw");
        $display("stop control done");
        cmd(CMD_SEL_REG, 32'h0000_0012);
        cmd(CMD_WR_REG, 32'hcafe_0001);
        chk(32'(we_a), 32'h0000_0012, "write select");
        chk(we_d, 32'hcafe_0001, "write data");
        cmd(CMD_RD_REG, 32'h0000_0000);
        chk(32'(re_a), 32'h0000_0012, "read select");
        cmd(CMD_NOP, 32'h0000_0000);
        chk(ans[31:0], 32'h5a5a_5a12, "read data");
        chk(32'(ans[38:32]), 32'h0000_0014, "status word");
        chk(32'(ans[39]), 32'((ncmd - 1) % 2), "ack toggle");
        cmd(CMD_IC_ADDR, 32'h0000_0100);
        cmd(CMD_IC_WR, 32'h1111_0000);
        cmd(CMD_IC_WR, 32'h2222_0000);
        chk(32'(ic_n), 32'h0000_0002, "fill count");
        chk(ic_a, 32'h0000_0104, "fill address");
        chk(ic_d, 32'h2222_0000, "fill word");
        $display("resource access done");
        cmd(CMD_STEP, 32'h0000_0000);
        chk(32'(stop), 32'h0000_0000, "stepping runs");
        retire(32'h0000_0040);
        chk(32'({stop, tv}), 32'h0000_0003, "step stops");
        chk(tpc, 32'h0000_0040, "trace address");
        cmd(CMD_RESUME, 32'h0000_0000);
        cmd(CMD_SET_BP, 32'h0000_0200);
        retire(32'h0000_01fc);
        chk(32'(stop), 32'h0000_0000, "no breakpoint hit");
        retire(32'h0000_0200);
        chk(32'({stop, tev}), 32'h0000_0003, "breakpoint hit");
        cmd(CMD_CLR_BP, 32'h0000_0000);
        cmd(CMD_RESUME, 32'h0000_0000);
        retire(32'h0000_0200);
        chk(32'({stop, tv}), 32'h0000_0001, "cleared breakpoint");
        $display("step and breakpoint done");
        fire(2'h2, 1'b1);
        chk(32'({stop, wt, tev}), 32'h0000_0007, "wait entry");
        repeat (5) @(negedge sys_clk);
        chk(32'({stop, wt, take}), 32'h0000_0006, "wait holds");
        irq = 1'b1;
        for (int i = 0; i < 6 && take !== 1'b1; i++) @(negedge sys_clk);
        chk(32'({stop, wt, take}), 32'h0000_0003, "interrupt taken");
        irq = 1'b0;
        repeat (3) @(negedge sys_clk);
        isr = 1'b1;
        @(negedge sys_clk);
        isr = 1'b0;
        chk(32'({stop, wt}), 32'h0000_0003, "back to wait");
        cmd(CMD_RESUME, 32'h0000_0000);
        chk(32'({stop, wt}), 32'h0000_0000, "resume from wait");
        cmd(CMD_HALT, 32'h0000_0000);
        chk(32'({stop, wt}), 32'h0000_0002, "halt stops");
        cmd(CMD_RESUME, 32'h0000_0000);
        chk(32'(ans[38:32]), 32'h0000_0018, "halt status");
        chk(32'(stop), 32'h0000_0000, "resume after halt");
        for (int m = 0; m < 4; m += 3) begin
            fire(2'(m), 1'b0);
            chk(32'({exc, stop, tev}), 32'h0000_0005, "internal trap");
        end
        $display("mode handling done");
        complete_run();
    end
endmodule : tb
`default_nettype wire
